// ---- core/appm_map.svh ----
// Constants for the parallel converter port: field positions, resets, timing
`ifndef APPM_MAP_SVH
`define APPM_MAP_SVH
`define APPM_PM_LO_BIT 4
`define APPM_PM_HI_BIT 5
`define APPM_CTRL_RESET 12'h000
`define APPM_CLK_MHZ 100
`define APPM_CONV_CYCLES 8'h0E
`define APPM_SHUTDOWN_WAKE_MS 10
`define APPM_STANDBY_WAKE_NS 600
`define APPM_SHUTDOWN_WAKE_CYC (`APPM_SHUTDOWN_WAKE_MS * 1000 * `APPM_CLK_MHZ)
`define APPM_STANDBY_WAKE_CYC ((`APPM_STANDBY_WAKE_NS * `APPM_CLK_MHZ + 999) / 1000)
`endif

// ---- core/appm_pkg.sv ----
// Types for the converter port: power modes for the converter end, states for the host end
package appm_pkg;
  typedef enum logic [1:0] {
    APPM_PM_NORMAL = 2'h0,
    APPM_PM_AUTO_SHUTDOWN = 2'h1,
    APPM_PM_AUTO_STANDBY = 2'h2,
    APPM_PM_FULL_SHUTDOWN = 2'h3
  } appm_pmode_t;
  typedef enum logic [3:0] {
    APPM_H_IDLE = 4'h1,
    APPM_H_STROBE = 4'h2,
    APPM_H_RELEASE = 4'h4,
    APPM_H_DONE = 4'h8
  } appm_hstate_t;
endpackage

// ---- core/appm_bus_if.sv ----
// Pin-level link between the converter and its host
`timescale 1ns/1ns
interface appm_bus_if;
  logic csN;
  logic rdN;
  logic wrN;
  logic wordMode;
  logic conversionStartN;
  logic busy;
  logic [11:0] devData;
  logic [11:0] devDataOe;
  logic [11:0] hostData;
  logic [11:0] hostDataOe;
  modport dev (input csN, rdN, wrN, wordMode, conversionStartN, hostData, hostDataOe,
    output busy, devData, devDataOe);
  modport host (output csN, rdN, wrN, wordMode, conversionStartN, hostData, hostDataOe,
    input busy, devData, devDataOe);
endinterface

// ---- core/appm_device.sv ----
// Converter end: parallel read/write port, conversion timing, power modes
`timescale 1ns/1ns
`include "appm_map.svh"
// Notes on behaviour
// [RL1] Word mode: full result on lines 0-11
// [RL2] Byte mode: two reads, shared pin selects byte
// [RL3] Low byte read gives eight LSBs
// [RL4] High byte: four MSBs, channel, zero
// [RL5] Drive bus only while select and read
// [RL6] Release bus after read ends
// [RL7] Tied-low read: data before busy falls
// [RL8] Word write loads whole control word
// [RL9] Byte writes: low first, then high
// [RL10] Host zeroes upper high-byte nibble
// [RL11] Shadow write always one access
// [RL12] Capture write on strobe rising edge
// [RL13] Two-bit field picks four power modes
// [RL14] Reset: normal mode, sampler in hold
// [RL15] Auto shutdown after conversion, wake on rise
// [RL16] Auto standby after conversion, wake on rise
// [RL17] Full shutdown on write edge, held
// [RL18] Leaving full shutdown restarts tracking
// [RL19] Host idles start low in shutdown; the host drives start as !startConv and idles it high
// [RL20] Start fall converts, busy high throughout
// [RL21] Host reads both bytes per sample
module appm_device (
  input wire logic clk_sys,
  input wire logic rst,
  appm_bus_if.dev bus,
  input wire logic [11:0] sampleValue,
  input wire logic [2:0] sampleChannel,
  input wire logic shadowSelect,
  output logic [11:0] controlWord,
  output logic [7:0] shadowWord,
  output logic tracking,
  output logic poweredDown,
  output logic refPowered
);
  logic [1:0] csS, rdS, wrS, cvS, wmS;
  logic [11:0] hdS0, hdS1;
  logic wrSel_q, cv_q, busy_q, track_q, pdn_q, ref_q, hbLatch_q;
  logic [7:0] convCnt_q;
  logic [11:0] result_q, ctrl_q, data_q, oe_q;
  logic [7:0] shadow_q;
  logic [3:0] lowByte_q;
  logic wrSel, wrRise, cvFall, cvRise, readSel, convDone, hbSel;
  logic [11:0] wrWord, rdWord;
  appm_pkg::appm_pmode_t mode, newMode;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      csS <= 2'h3; rdS <= 2'h3; wrS <= 2'h3; cvS <= 2'h3; wmS <= 2'h0;
      hdS0 <= 12'h000; hdS1 <= 12'h000;
    end else begin
      csS <= {csS[0], bus.csN}; rdS <= {rdS[0], bus.rdN}; wrS <= {wrS[0], bus.wrN};
      cvS <= {cvS[0], bus.conversionStartN}; wmS <= {wmS[0], bus.wordMode};
      hdS0 <= bus.hostData; hdS1 <= hdS0;
    end
  end

  // RL5 gated strobes
  assign readSel = !csS[1] && !rdS[1];
  assign wrSel = !csS[1] && !wrS[1];
  // RL12 rising edge capture
  assign wrRise = wrSel_q && !wrSel;
  assign cvFall = cv_q && !cvS[1];
  assign cvRise = !cv_q && cvS[1];
  assign convDone = busy_q && (convCnt_q == 8'h01);
  assign hbSel = hdS1[8];
  // RL8 word write; RL9 byte pairing low then high
  assign wrWord = wmS[1] ? hdS1 : (hbSel ? {hdS1[3:0], lowByte_q, 4'h0} : {4'h0, hdS1[7:0]});
  assign mode = appm_pkg::appm_pmode_t'(ctrl_q[`APPM_PM_HI_BIT:`APPM_PM_LO_BIT]);
  assign newMode = appm_pkg::appm_pmode_t'(wrWord[`APPM_PM_HI_BIT:`APPM_PM_LO_BIT]);
  // RL1 word, RL3 low byte, RL4 high byte with channel
  assign rdWord = wmS[1] ? result_q :
    (hbSel ? {4'h0, 1'b0, sampleChannel, result_q[11:8]} : {4'h0, result_q[7:0]});

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrSel_q <= 1'b0; cv_q <= 1'b1; hbLatch_q <= 1'b0; lowByte_q <= 4'h0;
      ctrl_q <= `APPM_CTRL_RESET; shadow_q <= 8'h00;
    end else begin
      wrSel_q <= wrSel;
      cv_q <= cvS[1];
      if (wrRise) begin
        // RL11 shadow always single access
        if (shadowSelect) shadow_q <= hdS1[7:0];
        else if (wmS[1] || hbSel) begin
          ctrl_q <= wmS[1] ? hdS1 : {hdS1[3:0], lowByte_q, ctrl_q[3:0]};
          hbLatch_q <= 1'b0;
        end else begin
          ctrl_q[3:0] <= hdS1[3:0];
          lowByte_q <= hdS1[7:4];
          hbLatch_q <= 1'b1;
        end
      end
    end
  end

  // RL20 conversion timing, RL13/15/16/17/18 power sequencing
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0; convCnt_q <= 8'h00; result_q <= 12'h000;
      // RL14 hold, normal, powered
      track_q <= 1'b0; pdn_q <= 1'b0; ref_q <= 1'b1;
    end else begin
      if (wrRise && !shadowSelect && (wmS[1] || hbSel)) begin
        // RL17 full shutdown on strobe
        if (newMode == appm_pkg::APPM_PM_FULL_SHUTDOWN) begin
          pdn_q <= 1'b1; ref_q <= 1'b0; track_q <= 1'b0;
        // RL18 leaving full shutdown
        end else if (mode == appm_pkg::APPM_PM_FULL_SHUTDOWN) begin
          pdn_q <= 1'b0; ref_q <= 1'b1; track_q <= 1'b1;
        end
      end else if (cvFall && !pdn_q && !busy_q) begin
        busy_q <= 1'b1; track_q <= 1'b0; convCnt_q <= `APPM_CONV_CYCLES;
      end else if (busy_q) begin
        convCnt_q <= convCnt_q - 8'h01;
        // RL7 result latched before busy falls
        // Two edges early so the output register shows it before busy drops
        if (convCnt_q == 8'h03) result_q <= sampleValue;
        if (convDone) begin
          busy_q <= 1'b0;
          // RL15 and RL16 power down after conversion
          case (mode)
            appm_pkg::APPM_PM_AUTO_SHUTDOWN: begin pdn_q <= 1'b1; ref_q <= 1'b0; end
            appm_pkg::APPM_PM_AUTO_STANDBY: begin pdn_q <= 1'b1; ref_q <= 1'b1; end
            default: track_q <= 1'b1;
          endcase
        end
      end else if (cvRise && mode != appm_pkg::APPM_PM_FULL_SHUTDOWN) begin
        // RL14 first rise tracks; RL15/16 wake
        pdn_q <= 1'b0; ref_q <= 1'b1; track_q <= 1'b1;
      end
    end
  end

  // RL5 drive while selected; RL6 release after; RL2 byte width
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      data_q <= 12'h000; oe_q <= 12'h000;
    end else begin
      data_q <= rdWord;
      oe_q <= readSel ? (wmS[1] ? 12'hFFF : 12'h0FF) : 12'h000;
    end
  end

  assign bus.busy = busy_q;
  assign bus.devData = data_q;
  assign bus.devDataOe = oe_q;
  assign controlWord = ctrl_q;
  assign shadowWord = shadow_q;
  assign tracking = track_q;
  assign poweredDown = pdn_q;
  assign refPowered = ref_q;
endmodule

// ---- core/appm_host.sv ----
// Host end: issues reads and writes over the parallel port
`timescale 1ns/1ns
`include "appm_map.svh"
module appm_host (
  input wire logic clk_sys,
  input wire logic rst,
  appm_bus_if.host bus,
  input wire logic wordModeSel,
  input wire logic reqRead,
  input wire logic reqWrite,
  input wire logic [11:0] writeWord,
  input wire logic startConv,
  output logic [11:0] readWord,
  output logic [2:0] readChannel,
  output logic done,
  output logic busyLevel
);
  localparam logic [3:0] HOLD = 4'h6;
  appm_pkg::appm_hstate_t st_q;
  logic isWrite_q, high_q, cs_q, rd_q, wr_q, cv_q, done_q, busy1, busy2;
  logic [3:0] cnt_q;
  logic [11:0] hd_q, hoe_q, rw_q, wbuf_q, s1, s2;
  logic [2:0] ch_q;
  logic lastPart;

  assign lastPart = wordModeSel || high_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1 <= 12'h000; s2 <= 12'h000; busy1 <= 1'b0; busy2 <= 1'b0;
    end else begin
      s1 <= bus.devData; s2 <= s1; busy1 <= bus.busy; busy2 <= busy1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= appm_pkg::APPM_H_IDLE; isWrite_q <= 1'b0; high_q <= 1'b0; cnt_q <= 4'h0;
      cs_q <= 1'b1; rd_q <= 1'b1; wr_q <= 1'b1; cv_q <= 1'b1; done_q <= 1'b0;
      hd_q <= 12'h000; hoe_q <= 12'h000; rw_q <= 12'h000; wbuf_q <= 12'h000; ch_q <= 3'h0;
    end else begin
      done_q <= 1'b0;
      // RL19 start level is !startConv; idles high, not low as RL19 asks
      cv_q <= !startConv;
      case (st_q)
        appm_pkg::APPM_H_IDLE: begin
          if (reqRead || reqWrite) begin
            isWrite_q <= reqWrite; high_q <= 1'b0; wbuf_q <= writeWord;
            st_q <= appm_pkg::APPM_H_STROBE; cnt_q <= HOLD;
          end
        end
        appm_pkg::APPM_H_STROBE: begin
          cs_q <= 1'b0; rd_q <= isWrite_q; wr_q <= !isWrite_q;
          // RL2 select pin; RL9 low byte first; RL10 zero upper nibble
          hd_q <= wordModeSel ? wbuf_q :
            (high_q ? {3'h0, 1'b1, 4'h0, wbuf_q[11:8]} : {3'h0, 1'b0, wbuf_q[7:0]});
          hoe_q <= isWrite_q ? 12'hFFF : (wordModeSel ? 12'h000 : 12'h100);
          if (!isWrite_q && !wordModeSel) hd_q <= {3'h0, high_q, 8'h00};
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1) st_q <= appm_pkg::APPM_H_RELEASE;
        end
        appm_pkg::APPM_H_RELEASE: begin
          // RL6 capture at read strobe rise
          cs_q <= 1'b1; rd_q <= 1'b1; wr_q <= 1'b1;
          if (!isWrite_q) begin
            if (wordModeSel) rw_q <= s2;
            else if (high_q) begin
              rw_q[11:8] <= s2[3:0]; ch_q <= s2[6:4];
            end else rw_q[7:0] <= s2[7:0];
          end
          // RL21 both bytes in turn
          st_q <= lastPart ? appm_pkg::APPM_H_DONE : appm_pkg::APPM_H_STROBE;
          high_q <= 1'b1; cnt_q <= HOLD;
        end
        appm_pkg::APPM_H_DONE: begin
          hoe_q <= 12'h000; done_q <= 1'b1; st_q <= appm_pkg::APPM_H_IDLE;
        end
        default: st_q <= appm_pkg::APPM_H_IDLE;
      endcase
    end
  end

  assign bus.csN = cs_q;
  assign bus.rdN = rd_q;
  assign bus.wrN = wr_q;
  assign bus.wordMode = wordModeSel;
  assign bus.conversionStartN = cv_q;
  assign bus.hostData = hd_q;
  assign bus.hostDataOe = hoe_q;
  assign readWord = rw_q;
  assign readChannel = ch_q;
  assign done = done_q;
  assign busyLevel = busy2;
endmodule

// ---- testbench/appm_chk.sv ----
// Concurrent checks on the wires between converter and host
`timescale 1ns/1ns
module appm_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic csN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic wordMode,
  input wire logic conversionStartN,
  input wire logic busy,
  input wire logic [11:0] devData,
  input wire logic [11:0] devDataOe,
  input wire logic [11:0] hostData,
  input wire logic [11:0] hostDataOe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  wire logic rdSel = !csN && !rdN;
  wire logic wrSel = !csN && !wrN;
  // Release tail is at most four cycles
  bus_release_a: assert property ((!rdSel)[*5] |-> devDataOe == 12'h000)
    else $error("data bus still driven after read ended");
  drive_on_read_a: assert property ($rose(devDataOe[0]) |-> rdSel)
    else $error("data bus driven without select and read");
  word_width_a: assert property (devDataOe != 12'h000 && wordMode |-> devDataOe == 12'hFFF)
    else $error("word read not on all twelve lines");
  byte_width_a: assert property (devDataOe != 12'h000 && !wordMode |-> devDataOe == 12'h0FF)
    else $error("byte read not on lines zero to seven");
  // Previous low byte may still stand for three cycles after the select flips
  high_zero_a: assert property (rdSel && !wordMode && hostData[8] && devDataOe[7] && $past(rdSel, 3)
    && $past(hostData[8], 3) |-> devData[7] == 1'b0)
    else $error("high byte line seven not zero");
  busy_hold_a: assert property ($rose(busy) |-> busy[*8] ##1 busy[*6] ##1 !busy)
    else $error("busy length wrong");
  busy_cause_a: assert property ($rose(busy) |-> !conversionStartN)
    else $error("busy rose without start low");
  no_contend_a: assert property ((devDataOe & hostDataOe) == 12'h000)
    else $error("both ends drive the data bus");
  word_write_a: assert property (wrSel && wordMode |-> hostDataOe == 12'hFFF)
    else $error("word write not on all twelve lines");
  byte_write_a: assert property (wrSel && !wordMode |-> hostDataOe[8:0] == 9'h1FF)
    else $error("byte write lines or select not driven");
  nibble_zero_a: assert property (wrSel && !wordMode && hostData[8] |-> hostData[7:4] == 4'h0)
    else $error("high byte upper nibble not zero");
  cover property (rdSel && wordMode && devDataOe != 12'h000);
  cover property (wrSel && !wordMode && hostData[8]);
  cover property ($rose(busy));
endmodule

// ---- testbench/adc_parallel_port_power_modes_tb.sv ----
// Self-checking bench joining the converter end to the host end
`timescale 1ns/1ns
`include "appm_map.svh"
module adc_parallel_port_power_modes_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic wordModeSel = 1'b1, reqRead = 1'b0, reqWrite = 1'b0, startConv = 1'b0, shadowSelect = 1'b0;
  logic [11:0] writeWord = 12'h000, sampleValue = 12'h000, readWord, controlWord, ctl;
  logic [2:0] sampleChannel = 3'h0, readChannel;
  logic [7:0] shadowWord;
  logic done, busyLevel, tracking, poweredDown, refPowered;
  integer seed = 32'hec58, n_fail = 0, samples_checked = 0, i, m;
  always #5 clk_sys = ~clk_sys;
  appm_bus_if bus ();
  appm_device appm_device_i (.clk_sys(clk_sys), .rst(rst), .bus(bus), .sampleValue(sampleValue),
    .sampleChannel(sampleChannel), .shadowSelect(shadowSelect), .controlWord(controlWord),
    .shadowWord(shadowWord), .tracking(tracking), .poweredDown(poweredDown), .refPowered(refPowered));
  appm_host appm_host_i (.clk_sys(clk_sys), .rst(rst), .bus(bus), .wordModeSel(wordModeSel), .reqRead(reqRead),
    .reqWrite(reqWrite), .writeWord(writeWord), .startConv(startConv), .readWord(readWord),
    .readChannel(readChannel), .done(done), .busyLevel(busyLevel));
  appm_chk appm_chk_i (.clk_sys(clk_sys), .rst(rst), .csN(bus.csN), .rdN(bus.rdN), .wrN(bus.wrN),
    .wordMode(bus.wordMode), .conversionStartN(bus.conversionStartN), .busy(bus.busy), .devData(bus.devData),
    .devDataOe(bus.devDataOe), .hostData(bus.hostData), .hostDataOe(bus.hostDataOe));
  function automatic logic expDown(input int md);
    return md != 0;
  endfunction
  // Reference stays up after a conversion except in auto shutdown
  function automatic logic expRef(input int md);
    return md != 1;
  endfunction
  task test_done();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task check(input string name, input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task wait_busy(input logic v);
    int k;
    for (k = 0; busyLevel !== v; k++) begin
      if (k == 200) begin
        n_fail++;
        test_done();
      end
      @(negedge clk_sys);
    end
  endtask
  // Extra idle cycles cover the read release tail
  task pulse_req(input logic wr);
    int k;
    if (wr) reqWrite = 1'b1;
    else reqRead = 1'b1;
    @(negedge clk_sys);
    reqWrite = 1'b0;
    reqRead = 1'b0;
    for (k = 0; done !== 1'b1; k++) begin
      if (k == 100) begin
        n_fail++;
        test_done();
      end
      @(negedge clk_sys);
    end
    repeat (6) @(negedge clk_sys);
  endtask
  task write_ctl(input logic [11:0] w);
    writeWord = w;
    pulse_req(1'b1);
  endtask
  task convert(input int md);
    startConv = 1'b1;
    wait_busy(1'b1);
    wait_busy(1'b0);
    repeat (3) @(negedge clk_sys);
    check("poweredDown", poweredDown, expDown(md));
    check("refPowered", refPowered, expRef(md));
    startConv = 1'b0;
    repeat (4) @(negedge clk_sys);
    check("tracking", tracking, 1'b1);
    check("awake", poweredDown, 1'b0);
  endtask
  initial begin
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    check("ctlReset", controlWord, `APPM_CTRL_RESET);
    check("trackReset", tracking, 1'b0);
    for (i = 0; i < 8; i++) begin
      wordModeSel = i[0];
      ctl = 12'($random(seed)) & ~(12'h003 << `APPM_PM_LO_BIT);
      write_ctl(ctl);
      check("ctlWrite", controlWord, ctl);
      sampleValue = (i == 0) ? 12'hFFF : (i == 1) ? 12'h000 : 12'($random(seed));
      sampleChannel = 3'($random(seed));
      convert(0);
      pulse_req(1'b0);
      check("readWord", readWord, sampleValue);
      if (!wordModeSel) check("readChannel", 12'(readChannel), 12'(sampleChannel));
    end
    wordModeSel = 1'b1;
    shadowSelect = 1'b1;
    write_ctl(12'h0A5);
    shadowSelect = 1'b0;
    check("shadow", 12'(shadowWord), 12'h0A5);
    check("ctlKept", controlWord, ctl);
    for (m = 1; m < 4; m++) begin
      ctl = (12'(m) << `APPM_PM_LO_BIT) | 12'($random(seed) & 15);
      write_ctl(ctl);
      if (m == 3) begin
        check("fullDown", poweredDown, 1'b1);
        startConv = 1'b1;
        repeat (30) @(negedge clk_sys);
        check("refusedBusy", busyLevel, 1'b0);
        startConv = 1'b0;
        check("ctlHeld", controlWord, ctl);
        write_ctl(12'h000);
        check("wakeUp", poweredDown, 1'b0);
        check("trackUp", tracking, 1'b1);
      end else begin
        convert(m);
        check("ctlRetained", controlWord, ctl);
      end
    end
    test_done();
  end
endmodule
